// File: hw/pamx_bbm.sv
// Purpose : Break-before-make gate on one port's direction bits
// Assumes : Direction register changes only on a register write
// Notes   : A 0 to 1 step is held low for one cycle while enabled

`timescale 1ns/1ps

module pamx_bbm
   import pamx_pkg::*;
#(
   parameter int unsigned W = PAMX_PORT_W
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   // Control
   input  wire logic         en_in,
   input  wire logic [W-1:0] dir_in,
   // Gated direction
   output      logic [W-1:0] dir_out
);

   logic [W-1:0] prev_r;
   logic [W-1:0] rise;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) prev_r <= '0;
      else prev_r <= dir_in;
   end

   // Newly made outputs float for one cycle before the driver turns on
   assign rise    = dir_in & ~prev_r;
   assign dir_out = en_in ? (dir_in & ~rise) : dir_in; // [R2]

endmodule : pamx_bbm

// File: hw/pamx_pin_cell.sv
// Purpose : Override merge for one port pin
// Assumes : Override bundle comes from the alternate function decode
// Notes   : Purely combinational

`timescale 1ns/1ps

module pamx_pin_cell
   import pamx_pkg::*;
(
   // Ordinary port control
   input  wire logic         dir_in,
   input  wire logic         port_in,
   input  wire logic         pud_in,
   // Alternate function overrides
   input  wire pamx_pinctl_s ovr_in,
   // Pad controls
   output      logic         oe_n_out,
   output      logic         val_out,
   output      logic         pullup_out
);

   logic drive;

   assign drive      = ovr_in.ddoe ? ovr_in.ddov : dir_in; // [R19]
   assign oe_n_out   = ~drive;
   assign val_out    = ovr_in.pvoe ? ovr_in.pvov : port_in;
   assign pullup_out = ovr_in.puoe ? ovr_in.puov : (~dir_in & port_in & ~pud_in); // [R17]

endmodule : pamx_pin_cell

// File: hw/pamx_pkg.sv
// Purpose : Constants, register map and pin override types for the port A/B pin control block
// Assumes : APB register access, 32-bit data, one aligned word per register
// Notes   : Behaviour list below; tags appear in the design files
//
// Behaviour
// R1 - Break-before-make enable bits 5 and 4 act on their own port only
// R2 - With break-before-make, a pin turned to output floats one cycle first
// R3 - Port pull-up disable bit turns off every pull-up of that port
// R4 - Effective port pull-up disable is port bit OR global disable
// R5 - Pin 7 outputs internal reference when enabled and an internal reference is selected
// R6 - Internal reference output turns off pin 7 driver and pull-up
// R7 - External reference or bypass use turns off pin 7 driver and pull-up
// R8 - SPI slave forces pin 6 to input, port bit keeps pull-up control
// R9 - SPI slave is active only while slave select is driven low
// R10 - SPI master leaves slave select direction to its direction bit
// R11 - SPI clock pin is input as slave, own direction as master
// R12 - MOSI pin is input as slave, own direction as master
// R13 - Software sets pin 4 as input for three-wire data input
// R14 - Software sets pin 2 as output for timer 0 compare output
// R15 - Three-wire data output replaces pin 2 port value when output
// R16 - Pin 2 is input as SPI master, own direction as slave
// R17 - Plain pull-up is on only for direction 0, port 1, disable 0
// R18 - Global pull-up disable turns off pull-ups on all ports
// R19 - Unclaimed pins follow direction, port bit and effective disable only

package pamx_pkg;

   // ==========================================================
   // Widths
   localparam int unsigned PAMX_PORT_W = 8;
   localparam int unsigned PAMX_ADDR_W = 12;
   localparam int unsigned PAMX_DATA_W = 32;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [11:0] PAMX_OFS_PORT_CTRL = 12'h000;
   localparam logic [11:0] PAMX_OFS_MCU_CTRL  = 12'h004;
   localparam logic [11:0] PAMX_OFS_ALT_CTRL  = 12'h008;
   localparam logic [11:0] PAMX_OFS_A_DIR     = 12'h00c;
   localparam logic [11:0] PAMX_OFS_A_OUT     = 12'h010;
   localparam logic [11:0] PAMX_OFS_A_PIN     = 12'h014;
   localparam logic [11:0] PAMX_OFS_B_DIR     = 12'h018;
   localparam logic [11:0] PAMX_OFS_B_OUT     = 12'h01c;
   localparam logic [11:0] PAMX_OFS_B_PIN     = 12'h020;

   // ==========================================================
   // Field positions
   localparam int unsigned PAMX_PC_BBM_B   = 5;
   localparam int unsigned PAMX_PC_BBM_A   = 4;
   localparam int unsigned PAMX_PC_PUD_B   = 1;
   localparam int unsigned PAMX_PC_PUD_A   = 0;
   localparam int unsigned PAMX_MCU_PUD    = 4;
   localparam int unsigned PAMX_ALT_SPI_EN = 0;
   localparam int unsigned PAMX_ALT_SPI_MS = 1;
   localparam int unsigned PAMX_ALT_REF_OE = 2;
   localparam int unsigned PAMX_ALT_REF_LO = 4;
   localparam int unsigned PAMX_ALT_USI3   = 6;
   localparam int unsigned PAMX_ALT_TMR0   = 7;

   // Writable bits of the mcu control register
   localparam logic [7:0] PAMX_MCU_WMASK = 8'h70;

   // Reference selection codes; bit 1 set means an internal value
   localparam logic [1:0] PAMX_REF_SUPPLY = 2'h0;
   localparam logic [1:0] PAMX_REF_EXT    = 2'h1;
   localparam logic [1:0] PAMX_REF_1V1    = 2'h2;
   localparam logic [1:0] PAMX_REF_2V56   = 2'h3;

   // ==========================================================
   // Reset values
   localparam logic [7:0] PAMX_RST_PORT_CTRL = 8'h00;
   localparam logic [7:0] PAMX_RST_MCU_CTRL  = 8'h00;
   localparam logic [7:0] PAMX_RST_ALT_CTRL  = 8'h00;
   localparam logic [7:0] PAMX_RST_DIR       = 8'h00;
   localparam logic [7:0] PAMX_RST_OUT       = 8'h00;

   // ==========================================================
   // Override bundle for one pin
   typedef struct packed {
      logic ddoe;
      logic ddov;
      logic pvoe;
      logic pvov;
      logic puoe;
      logic puov;
   } pamx_pinctl_s;

   localparam pamx_pinctl_s PAMX_NO_OVR = '0;

   // Pin forced to input; the port bit still drives the pull-up
   function automatic pamx_pinctl_s pamx_forced_in(input logic port_bit, input logic global_pullup_off);
      pamx_pinctl_s c;
      c      = PAMX_NO_OVR;
      c.ddoe = 1'b1;
      c.ddov = 1'b0;
      c.puoe = 1'b1;
      c.puov = port_bit & ~global_pullup_off;
      return c;
   endfunction : pamx_forced_in

   // Pin driven by a peripheral value while the direction bit stays in charge
   function automatic pamx_pinctl_s pamx_value_ovr(input logic val);
      pamx_pinctl_s c;
      c      = PAMX_NO_OVR;
      c.pvoe = 1'b1;
      c.pvov = val;
      return c;
   endfunction : pamx_value_ovr

endpackage : pamx_pkg

// File: hw/pamx_top.sv
// Purpose : Port A/B pin control with alternate function overrides on port A pins 7..4 and 2
// Assumes : APB slave, zero wait states, pins synchronous to SYS_CLK_IN
// Notes   : Pad output enables are active low
//
// The placing of the registers and the APB interface to the registers were left to the implementer.

`timescale 1ns/1ps

module pamx_top
   import pamx_pkg::*;
(
   // Clock and reset
   input  wire logic                   SYS_CLK_IN,
   input  wire logic                   RSTN_IN,
   // APB slave
   input  wire logic                   PSEL_IN,
   input  wire logic                   PENABLE_IN,
   input  wire logic                   PWRITE_IN,
   input  wire logic [PAMX_ADDR_W-1:0] PADDR_IN,
   input  wire logic [PAMX_DATA_W-1:0] PWDATA_IN,
   output      logic [PAMX_DATA_W-1:0] PRDATA_OUT,
   output      logic                   PREADY_OUT,
   output      logic                   PSLVERR_OUT,
   // Peripheral drive values
   input  wire logic                   SPI_SCK_DRV_IN,
   input  wire logic                   SPI_MOSI_DRV_IN,
   input  wire logic                   SPI_MISO_DRV_IN,
   input  wire logic                   USI_DATA_DRV_IN,
   input  wire logic                   TMR0_CMP_A_IN,
   // Peripheral status
   output      logic                   SPI_SLAVE_ACTIVE_OUT,
   output      logic                   REF_OUT_EN_OUT,
   // Port A pads
   input  wire logic [PAMX_PORT_W-1:0] PA_IN,
   output      logic [PAMX_PORT_W-1:0] PA_OUT,
   output      logic [PAMX_PORT_W-1:0] PA_OE_N_OUT,
   output      logic [PAMX_PORT_W-1:0] PA_PULLUP_OUT,
   // Port B pads
   input  wire logic [PAMX_PORT_W-1:0] PB_IN,
   output      logic [PAMX_PORT_W-1:0] PB_OUT,
   output      logic [PAMX_PORT_W-1:0] PB_OE_N_OUT,
   output      logic [PAMX_PORT_W-1:0] PB_PULLUP_OUT
);

   // ==========================================================
   // Registers
   logic [7:0]             port_ctrl_r;
   logic [7:0]             mcu_ctrl_r;
   logic [7:0]             alt_ctrl_r;
   logic [PAMX_PORT_W-1:0] a_dir_r;
   logic [PAMX_PORT_W-1:0] a_out_r;
   logic [PAMX_PORT_W-1:0] b_dir_r;
   logic [PAMX_PORT_W-1:0] b_out_r;
   logic [PAMX_DATA_W-1:0] prdata_r;
   logic                   pslverr_r;

   // ==========================================================
   // APB decode
   logic                   setup;
   logic                   wr_fire;
   logic                   hit_pc;
   logic                   hit_mcu;
   logic                   hit_alt;
   logic                   hit_adir;
   logic                   hit_aout;
   logic                   hit_apin;
   logic                   hit_bdir;
   logic                   hit_bout;
   logic                   hit_bpin;
   logic                   hit_any;
   logic [7:0]             wbyte;
   logic [7:0]             rd_byte;

   assign setup    = PSEL_IN & ~PENABLE_IN;
   assign wr_fire  = PSEL_IN & PENABLE_IN & PWRITE_IN;
   assign hit_pc   = (PADDR_IN == PAMX_OFS_PORT_CTRL);
   assign hit_mcu  = (PADDR_IN == PAMX_OFS_MCU_CTRL);
   assign hit_alt  = (PADDR_IN == PAMX_OFS_ALT_CTRL);
   assign hit_adir = (PADDR_IN == PAMX_OFS_A_DIR);
   assign hit_aout = (PADDR_IN == PAMX_OFS_A_OUT);
   assign hit_apin = (PADDR_IN == PAMX_OFS_A_PIN);
   assign hit_bdir = (PADDR_IN == PAMX_OFS_B_DIR);
   assign hit_bout = (PADDR_IN == PAMX_OFS_B_OUT);
   assign hit_bpin = (PADDR_IN == PAMX_OFS_B_PIN);
   assign hit_any  = hit_pc | hit_mcu | hit_alt | hit_adir | hit_aout | hit_apin
                   | hit_bdir | hit_bout | hit_bpin;
   assign wbyte    = PWDATA_IN[7:0];

   assign rd_byte = hit_pc   ? port_ctrl_r :
                    hit_mcu  ? mcu_ctrl_r  :
                    hit_alt  ? alt_ctrl_r  :
                    hit_adir ? a_dir_r     :
                    hit_aout ? a_out_r     :
                    hit_apin ? PA_IN       :
                    hit_bdir ? b_dir_r     :
                    hit_bout ? b_out_r     :
                    hit_bpin ? PB_IN       : 8'h00;

   // Read data and error are captured in the setup cycle
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         prdata_r  <= '0;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r  <= {24'h000000, rd_byte};
         pslverr_r <= ~hit_any;
      end
   end

   assign PRDATA_OUT  = prdata_r;
   assign PREADY_OUT  = 1'b1;
   assign PSLVERR_OUT = pslverr_r;

   // ==========================================================
   // Register writes
   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) port_ctrl_r <= PAMX_RST_PORT_CTRL;
      else if (wr_fire && hit_pc) port_ctrl_r <= wbyte; // [R1]
   end

   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) mcu_ctrl_r <= PAMX_RST_MCU_CTRL;
      else if (wr_fire && hit_mcu) mcu_ctrl_r <= wbyte & PAMX_MCU_WMASK;
   end

   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) alt_ctrl_r <= PAMX_RST_ALT_CTRL;
      else if (wr_fire && hit_alt) alt_ctrl_r <= wbyte;
   end

   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         a_dir_r <= PAMX_RST_DIR;
         a_out_r <= PAMX_RST_OUT;
      end else begin
         if (wr_fire && hit_adir) a_dir_r <= wbyte;
         if (wr_fire && hit_aout) a_out_r <= wbyte;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         b_dir_r <= PAMX_RST_DIR;
         b_out_r <= PAMX_RST_OUT;
      end else begin
         if (wr_fire && hit_bdir) b_dir_r <= wbyte;
         if (wr_fire && hit_bout) b_out_r <= wbyte;
      end
   end

   // ==========================================================
   // Control decode
   logic       pud_a_eff;
   logic       pud_b_eff;
   logic       spi_en;
   logic       spi_master;
   logic       spi_slave;
   logic [1:0] ref_sel;
   logic       ref_claim;
   logic       usi3;
   logic       tmr0;

   assign pud_a_eff  = port_ctrl_r[PAMX_PC_PUD_A] | mcu_ctrl_r[PAMX_MCU_PUD]; // [R3] [R4] [R18]
   assign pud_b_eff  = port_ctrl_r[PAMX_PC_PUD_B] | mcu_ctrl_r[PAMX_MCU_PUD]; // [R3] [R4] [R18]
   assign spi_en     = alt_ctrl_r[PAMX_ALT_SPI_EN];
   assign spi_master = spi_en & alt_ctrl_r[PAMX_ALT_SPI_MS];
   assign spi_slave  = spi_en & ~alt_ctrl_r[PAMX_ALT_SPI_MS];
   assign ref_sel    = alt_ctrl_r[PAMX_ALT_REF_LO +: 2];
   assign usi3       = alt_ctrl_r[PAMX_ALT_USI3];
   assign tmr0       = alt_ctrl_r[PAMX_ALT_TMR0];

   assign REF_OUT_EN_OUT = alt_ctrl_r[PAMX_ALT_REF_OE]
                         & ((ref_sel == PAMX_REF_1V1) | (ref_sel == PAMX_REF_2V56)); // [R5]
   // External reference, bypass capacitor or reference output all take the pin
   assign ref_claim      = REF_OUT_EN_OUT | (ref_sel != PAMX_REF_SUPPLY);

   assign SPI_SLAVE_ACTIVE_OUT = spi_slave & ~PA_IN[6]; // [R9]

   // ==========================================================
   // Alternate function overrides, port A
   pamx_pinctl_s ovr_a [PAMX_PORT_W];
   pamx_pinctl_s ovr_b [PAMX_PORT_W];
   pamx_pinctl_s ref_ovr;

   always_comb begin
      ref_ovr      = PAMX_NO_OVR;
      ref_ovr.ddoe = 1'b1;
      ref_ovr.puoe = 1'b1;
   end

   assign ovr_a[7] = ref_claim ? ref_ovr : PAMX_NO_OVR; // [R6] [R7]
   // Master leaves slave select untouched
   assign ovr_a[6] = spi_slave ? pamx_forced_in(a_out_r[6], pud_a_eff) // [R8] [R10]
                               : PAMX_NO_OVR;
   assign ovr_a[5] = spi_slave  ? pamx_forced_in(a_out_r[5], pud_a_eff) : // [R11]
                     spi_master ? pamx_value_ovr(SPI_SCK_DRV_IN) : PAMX_NO_OVR;
   // Three-wire data input uses the ordinary port control
   assign ovr_a[4] = spi_slave  ? pamx_forced_in(a_out_r[4], pud_a_eff) : // [R12]
                     spi_master ? pamx_value_ovr(SPI_MOSI_DRV_IN) : PAMX_NO_OVR;
   assign ovr_a[3] = PAMX_NO_OVR;
   // Timer output reaches the pad only while the direction bit is set
   assign ovr_a[2] = spi_master ? pamx_forced_in(a_out_r[2], pud_a_eff) : // [R16]
                     spi_slave  ? pamx_value_ovr(SPI_MISO_DRV_IN) :
                     usi3       ? pamx_value_ovr(USI_DATA_DRV_IN) :     // [R15]
                     tmr0       ? pamx_value_ovr(TMR0_CMP_A_IN) : PAMX_NO_OVR;
   assign ovr_a[1] = PAMX_NO_OVR;
   assign ovr_a[0] = PAMX_NO_OVR;

   // ==========================================================
   // Break-before-make and pin cells
   logic [PAMX_PORT_W-1:0] a_dir_g;
   logic [PAMX_PORT_W-1:0] b_dir_g;

   pamx_bbm #(.W(PAMX_PORT_W)) u_bbm_a (
      .clk_in  (SYS_CLK_IN),
      .rstn_in (RSTN_IN),
      .en_in   (port_ctrl_r[PAMX_PC_BBM_A]), // [R1]
      .dir_in  (a_dir_r),
      .dir_out (a_dir_g)
   );

   pamx_bbm #(.W(PAMX_PORT_W)) u_bbm_b (
      .clk_in  (SYS_CLK_IN),
      .rstn_in (RSTN_IN),
      .en_in   (port_ctrl_r[PAMX_PC_BBM_B]), // [R1]
      .dir_in  (b_dir_r),
      .dir_out (b_dir_g)
   );

   for (genvar i = 0; i < PAMX_PORT_W; i++) begin : g_pin
      assign ovr_b[i] = PAMX_NO_OVR;

      pamx_pin_cell u_cell_a (
         .dir_in     (a_dir_g[i]),
         .port_in    (a_out_r[i]),
         .pud_in     (pud_a_eff),
         .ovr_in     (ovr_a[i]),
         .oe_n_out   (PA_OE_N_OUT[i]),
         .val_out    (PA_OUT[i]),
         .pullup_out (PA_PULLUP_OUT[i])
      );

      pamx_pin_cell u_cell_b (
         .dir_in     (b_dir_g[i]),
         .port_in    (b_out_r[i]),
         .pud_in     (pud_b_eff),
         .ovr_in     (ovr_b[i]),
         .oe_n_out   (PB_OE_N_OUT[i]),
         .val_out    (PB_OUT[i]),
         .pullup_out (PB_PULLUP_OUT[i])
      );
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RSTN_IN);

   bbm_hold_a : assert property ( // [R2]
      $rose(a_dir_r[7]) && port_ctrl_r[PAMX_PC_BBM_A] && !ref_claim
      |-> PA_OE_N_OUT[7] ##1 !PA_OE_N_OUT[7])
      else $error("bbm: pin 7 not held floating for one cycle");

   bbm_port_a : assert property ( // [R1]
      $rose(b_dir_r[0]) && port_ctrl_r[PAMX_PC_BBM_A] && !port_ctrl_r[PAMX_PC_BBM_B]
      |-> !PB_OE_N_OUT[0])
      else $error("bbm: port A enable delayed a port B pin");

   pud_port_a : assert property ( // [R3]
      port_ctrl_r[PAMX_PC_PUD_A] |-> (PA_PULLUP_OUT == '0))
      else $error("pull-up on despite port disable");

   pud_global_a : assert property ( // [R4] [R18]
      mcu_ctrl_r[PAMX_MCU_PUD] |-> (PA_PULLUP_OUT == '0) && (PB_PULLUP_OUT == '0))
      else $error("pull-up on despite global disable");

   ref_out_a : assert property ( // [R5] [R6]
      $rose(REF_OUT_EN_OUT) |-> $past(wr_fire && hit_alt) && PA_OE_N_OUT[7]
                                && !PA_PULLUP_OUT[7])
      else $error("reference output with driver or pull-up active");

   ext_ref_a : assert property ( // [R7]
      ref_sel == PAMX_REF_EXT |-> PA_OE_N_OUT[7] && !PA_PULLUP_OUT[7])
      else $error("external reference pin still driven");

   ss_input_a : assert property ( // [R8]
      spi_slave |-> PA_OE_N_OUT[6] && (PA_PULLUP_OUT[6] == (a_out_r[6] && !pud_a_eff)))
      else $error("slave select not forced to input");

   ss_active_a : assert property ( // [R9]
      SPI_SLAVE_ACTIVE_OUT |-> spi_en && !PA_IN[6])
      else $error("slave active without select low");

   ss_master_a : assert property ( // [R10]
      spi_master && $stable(a_dir_r) |-> (PA_OE_N_OUT[6] == !a_dir_r[6]))
      else $error("slave select direction forced in master role");

   sck_pin_a : assert property ( // [R11]
      spi_master && $stable(a_dir_r) |-> (PA_OE_N_OUT[5] == !a_dir_r[5])
                                         && (PA_OUT[5] == SPI_SCK_DRV_IN))
      else $error("clock pin wrong in master role");

   mosi_pin_a : assert property ( // [R12]
      spi_slave |-> PA_OE_N_OUT[4] && (PA_PULLUP_OUT[4] == (a_out_r[4] && !pud_a_eff)))
      else $error("data pin not forced to input as slave");

   miso_pin_a : assert property ( // [R16]
      spi_master |-> PA_OE_N_OUT[2] && (PA_PULLUP_OUT[2] == (a_out_r[2] && !pud_a_eff)))
      else $error("pin 2 not forced to input as master");

   usi_out_a : assert property ( // [R15]
      !spi_en && usi3 && a_dir_r[2] && $stable(a_dir_r) |-> !PA_OE_N_OUT[2]
                                                          && (PA_OUT[2] == USI_DATA_DRV_IN))
      else $error("three-wire data not on pin 2");

   plain_pin_a : assert property ( // [R17] [R19]
      $stable(a_dir_r) |-> (PA_PULLUP_OUT[3] == (!a_dir_r[3] && a_out_r[3] && !pud_a_eff))
                           && (PA_OE_N_OUT[3] == !a_dir_r[3]) && (PA_OUT[3] == a_out_r[3]))
      else $error("plain pin 3 control wrong");

   ref_bypass_a : assert property ( // [R5] [R7]
      ref_sel[1] && !alt_ctrl_r[PAMX_ALT_REF_OE]
      |-> !REF_OUT_EN_OUT && PA_OE_N_OUT[7] && !PA_PULLUP_OUT[7])
      else $error("bypass reference pin still driven");

   sck_slave_a : assert property ( // [R11]
      spi_slave |-> PA_OE_N_OUT[5] && (PA_PULLUP_OUT[5] == (a_out_r[5] && !pud_a_eff)))
      else $error("clock pin not forced to input as slave");

   miso_slave_a : assert property ( // [R16]
      spi_slave && $stable(a_dir_r) |-> (PA_OE_N_OUT[2] == !a_dir_r[2])
                                        && (PA_OUT[2] == SPI_MISO_DRV_IN))
      else $error("pin 2 wrong in slave role");

   pud_b_a : assert property ( // [R3]
      port_ctrl_r[PAMX_PC_PUD_B] |-> (PB_PULLUP_OUT == '0))
      else $error("port B pull-up on despite port disable");

   plain_b_a : assert property ( // [R19]
      $stable(b_dir_r) |-> (PB_OE_N_OUT == ~b_dir_r) && (PB_OUT == b_out_r))
      else $error("port B pin control wrong");

   cov_slave_c : cover property (spi_slave ##1 SPI_SLAVE_ACTIVE_OUT);
   cov_bbm_c   : cover property ($rose(a_dir_r[7]) && port_ctrl_r[PAMX_PC_BBM_A]);
   cov_ref_c   : cover property ($rose(REF_OUT_EN_OUT));
   cov_err_c   : cover property (PSEL_IN && PENABLE_IN && PSLVERR_OUT);
   cov_mst_c   : cover property (spi_master && !PA_OE_N_OUT[6]);

endmodule : pamx_top

// File: verif/pamx_pad_model.sv
// Purpose : Pad and board model for one eight-pin port
// Assumes : Bench commands an external drive per pin
// Notes   : Undriven pins without pull-up toggle so no stale level is read

`timescale 1ns/1ps

module pamx_pad_model (
   input  wire logic       clk_in,
   input  wire logic [7:0] oe_n_in,
   input  wire logic [7:0] val_in,
   input  wire logic [7:0] pullup_in,
   input  wire logic [7:0] ext_en_in,
   input  wire logic [7:0] ext_val_in,
   output      logic [7:0] pin_out
);
   logic [7:0] flip_r;

   initial flip_r = 8'h55;
   always @(posedge clk_in) flip_r <= ~flip_r;

   // ==========================================================
   // Pad level: device drive, then external drive, then pull-up
   // External master may pull the select pin low
   assign pin_out = (~oe_n_in & val_in) | (oe_n_in & ext_en_in & ext_val_in)
                  | (oe_n_in & ~ext_en_in & (pullup_in | flip_r));
endmodule : pamx_pad_model

// File: verif/port_a_alt_function_override_test.sv
// Purpose : Self-checking bench for the port pin control block
// Assumes : Zero wait state APB slave, pads settle right after the write edge
// Notes   : Pads are checked 1 ns after the edge that changes them

`timescale 1ns/1ps

module port_a_alt_function_override_test;
   import pamx_pkg::*;
   logic        clk, rstn, psel, pen, pwr, sck, mosi, miso, usi_d, tmr0, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, slv_act, ref_en;
   logic [7:0]  pa_in, pa_out, pa_oe_n, pa_pu, pb_in, pb_out, pb_oe_n, pb_pu;
   logic [7:0]  a_en, a_val;
   int          bad_count, tests_run, cycles;

   pamx_top i_dut (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SPI_SCK_DRV_IN(sck),
      .SPI_MOSI_DRV_IN(mosi), .SPI_MISO_DRV_IN(miso), .USI_DATA_DRV_IN(usi_d),
      .TMR0_CMP_A_IN(tmr0), .SPI_SLAVE_ACTIVE_OUT(slv_act), .REF_OUT_EN_OUT(ref_en),
      .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE_N_OUT(pa_oe_n), .PA_PULLUP_OUT(pa_pu),
      .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE_N_OUT(pb_oe_n), .PB_PULLUP_OUT(pb_pu));
   pamx_pad_model i_pad_a (.clk_in(clk), .oe_n_in(pa_oe_n), .val_in(pa_out),
      .pullup_in(pa_pu), .ext_en_in(a_en), .ext_val_in(a_val), .pin_out(pa_in));
   pamx_pad_model i_pad_b (.clk_in(clk), .oe_n_in(pb_oe_n), .val_in(pb_out),
      .pullup_in(pb_pu), .ext_en_in(8'h00), .ext_val_in(8'h00), .pin_out(pb_in));

   // ==========================================================
   // Clock, reset and hang guard
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         test_done();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      #1;
   endtask : apb

   // ==========================================================
   // Scenarios
   task automatic t_plain();
      chk({pa_oe_n, pa_pu, 6'h0, ref_en, slv_act}, 32'h00ff0000);
      apb(1'b0, PAMX_OFS_PORT_CTRL, 8'h00);
      chk(rd, 32'h0);
      apb(1'b1, PAMX_OFS_A_DIR, 8'h0f);
      apb(1'b1, PAMX_OFS_A_OUT, 8'hf5);
      chk({pa_oe_n, pa_pu, pa_out & 8'h0f}, 32'hf0f005);
   endtask : t_plain
   task automatic t_pud();
      apb(1'b1, PAMX_OFS_B_OUT, 8'hff);
      apb(1'b1, PAMX_OFS_PORT_CTRL, 8'h01);
      chk({pa_pu, pb_pu}, 32'h00ff);
      apb(1'b0, PAMX_OFS_PORT_CTRL, 8'h00);
      chk(rd, 32'h01);
      apb(1'b1, PAMX_OFS_PORT_CTRL, 8'h02);
      chk({pa_pu, pb_pu}, 32'hf000);
      apb(1'b1, PAMX_OFS_MCU_CTRL, 8'hff);
      chk({pa_pu, pb_pu}, 32'h0000);
      apb(1'b0, PAMX_OFS_MCU_CTRL, 8'h00);
      chk(rd, 32'h70);
      apb(1'b1, PAMX_OFS_MCU_CTRL, 8'h00);
   endtask : t_pud
   task automatic t_bbm();
      apb(1'b1, PAMX_OFS_PORT_CTRL, 8'h10);
      apb(1'b1, PAMX_OFS_B_DIR, 8'hff);
      chk(pb_oe_n, 8'h00);
      apb(1'b1, PAMX_OFS_A_DIR, 8'hff);
      chk(pa_oe_n, 8'hf0);
      @(posedge clk);
      #1;
      chk(pa_oe_n, 8'h00);
      apb(1'b1, PAMX_OFS_PORT_CTRL, 8'h00);
   endtask : t_bbm
   task automatic t_spi();
      apb(1'b1, PAMX_OFS_A_OUT, 8'hfb);
      apb(1'b1, PAMX_OFS_ALT_CTRL, 8'h01);
      chk({pa_oe_n & 8'h74, pa_pu & 8'h70, 7'h0, pa_out[2]}, 32'h707001);
      @(posedge clk);
      a_en <= 8'h40;
      a_val <= 8'h00;
      #1;
      chk(slv_act, 1'b1);
      @(posedge clk);
      a_val <= 8'h40;
      #1;
      chk(slv_act, 1'b0);
      apb(1'b1, PAMX_OFS_ALT_CTRL, 8'h03);
      chk({pa_oe_n, pa_pu[2], slv_act}, 32'h0010);
      chk(pa_out[5:4], 2'b10);
      a_en <= 8'h00;
   endtask : t_spi
   task automatic t_ref();
      logic [7:0] alt [5] = '{8'h24, 8'h34, 8'h14, 8'h04, 8'h20};
      logic [1:0] exp [5] = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b00};
      apb(1'b1, PAMX_OFS_A_DIR, 8'h00);
      apb(1'b1, PAMX_OFS_A_OUT, 8'hff);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, PAMX_OFS_ALT_CTRL, alt[i]);
         chk({ref_en, pa_pu[7], pa_oe_n[7]}, {exp[i], 1'b1});
      end
   endtask : t_ref
   task automatic t_usi();
      // Software sets pin 4 as input and pin 2 as output
      apb(1'b1, PAMX_OFS_A_DIR, 8'h04);
      apb(1'b1, PAMX_OFS_A_OUT, 8'h00);
      apb(1'b1, PAMX_OFS_ALT_CTRL, 8'h40);
      chk({pa_oe_n[4], pa_out[2]}, 2'b11);
      @(posedge clk);
      usi_d <= 1'b0;
      #1;
      chk(pa_out[2], 1'b0);
      apb(1'b1, PAMX_OFS_ALT_CTRL, 8'h80);
      chk(pa_out[2], 1'b1);
      apb(1'b0, 12'h040, 8'h00);
      chk({err, rd[7:0]}, 9'h100);
   endtask : t_usi

   task automatic test_done();
      $display("Checks run %0d, errors %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done

   // ==========================================================
   // Main sequence
   initial begin
      rstn = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; sck = 1'b1; mosi = 1'b0; miso = 1'b1; usi_d = 1'b1;
      tmr0 = 1'b1; a_en = 8'h00; a_val = 8'h00; bad_count = 0; tests_run = 0;
      cycles = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      #1;
      t_plain();
      t_pud();
      t_bbm();
      t_spi();
      t_ref();
      t_usi();
      test_done();
   end
endmodule : port_a_alt_function_override_test
